// ### btcpm_pkg.sv
// constants, register map and state type of the battery temperature monitor
`default_nettype none
package btcpm_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int BIAS_TIME_MS = 25;
  localparam int DEGLITCH_TIME_MS = 10;
  localparam int MONITOR_TIME_MS = 100;
  localparam int BIAS_CYCLES = BIAS_TIME_MS * CYCLES_PER_MS;
  localparam int DEGLITCH_CYCLES = DEGLITCH_TIME_MS * CYCLES_PER_MS;
  localparam int MONITOR_CYCLES = MONITOR_TIME_MS * CYCLES_PER_MS;
  localparam int CNT_W = 20;
  // ==========================================================================
  // power reporting
  localparam int PWR_W = 16;
  localparam logic [15:0] POWER_MARGIN_MW = 16'h0177;
  localparam logic [15:0] POWER_SAT_MW = 16'hffff;
  // ==========================================================================
  // register word indexes, byte offset is four times the index
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h2;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'h3;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] IDX_RX_POWER = 4'h5;
  localparam logic [3:0] IDX_REF_POWER = 4'h6;
  localparam logic [3:0] IDX_POWER_TRIM = 4'h7;
  localparam logic [3:0] IDX_CMD = 4'h8;
  // ==========================================================================
  // fields
  localparam int CTRL_W = 2;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CHARGE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CMD_CLEAR = 0;
  localparam int ST_HOT = 0;
  localparam int ST_COLD = 1;
  localparam int ST_OVERRIDE = 2;
  localparam int ST_SHUTDOWN = 3;
  localparam int ST_COMPLETE = 4;
  localparam int ST_FAULT = 5;
  localparam int ST_DIE_SD = 6;
  localparam int ST_CHARGING = 7;
  localparam int ST_POWER_OK = 8;
  localparam int ST_BIAS = 9;
  localparam int ST_W = 10;
  localparam int IRQ_HOT = 0;
  localparam int IRQ_COLD = 1;
  localparam int IRQ_COMPLETE = 2;
  localparam int IRQ_FAULT = 3;
  localparam int IRQ_DIE_SD = 4;
  localparam int IRQ_CYCLE = 5;
  localparam int IRQ_W = 6;
  // ==========================================================================
  // measurement sequencer
  typedef enum logic [2:0] {
    BTCPM_IDLE = 3'b001,
    BTCPM_BIAS = 3'b010,
    BTCPM_MONITOR = 3'b100
  } btcpm_state_t;
endpackage
`default_nettype wire

// ### btcpm_deglitch.sv
// comparator deglitch filter counting stable clock cycles
`timescale 1ns/100ps
`default_nettype none
module btcpm_deglitch #(
  parameter int CYCLES = btcpm_pkg::DEGLITCH_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic raw_i,
  output logic filt_o,
  output logic rise_o
);
  // ==========================================================================
  // filter
  localparam logic [btcpm_pkg::CNT_W-1:0] LAST =
    btcpm_pkg::CNT_W'(CYCLES - 1);

  logic [btcpm_pkg::CNT_W-1:0] cnt;
  wire logic differs = en_i && (raw_i != filt_o);
  wire logic pass = differs && (cnt == LAST);

  // a raw level equal to the output again means a glitch, so count restarts
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cnt <= '0;
      filt_o <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      cnt <= (differs && !pass) ? btcpm_pkg::CNT_W'(cnt + 1'b1) : '0;
      if (pass)
        filt_o <= raw_i;
      rise_o <= pass && raw_i;
    end
  end
endmodule
`default_nettype wire

// ### btcpm_top.sv
// battery temperature sense and control pin monitor with avalon registers
// What this block does
// - hot and cold comparator inputs watch the sense pin.
// - each cycle starts with the bias strobe high for 25 ms.
// - comparators deglitched 10 ms during bias; only filtered results act.
// - after the bias window the strobe drops and the pin floats.
// - for 100 ms afterwards the pin is compared to control-high.
// - pin above control-high during the monitor window sets the override flag.
// - pin pulled above control-high: receiver shuts down, charge complete.
// - pin pulled below control-low: receiver shuts down, fault signalled.
// - die at limit turns regulator off until cooled by hysteresis.
// - report received power as output power plus losses.
// - report must lie below reference power by less than 375 mW.
// - charging only allowed while temperature lies inside the range.
`timescale 1ns/100ps
`default_nettype none
module btcpm_top #(
  parameter int BIAS_CYCLES = btcpm_pkg::BIAS_CYCLES,
  parameter int MONITOR_CYCLES = btcpm_pkg::MONITOR_CYCLES,
  parameter int DEGLITCH_CYCLES = btcpm_pkg::DEGLITCH_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic hot_cmp_i,
  input wire logic cold_cmp_i,
  input wire logic ctrl_high_cmp_i,
  input wire logic ctrl_low_cmp_i,
  input wire logic die_at_limit_i,
  input wire logic die_cooled_i,
  input wire logic [15:0] out_power_mw_i,
  input wire logic [15:0] loss_power_mw_i,
  output logic sense_bias_strobe_o,
  output logic temp_sense_ctrl_pin_o,
  output logic temp_sense_ctrl_pin_oe_o,
  output logic rx_shutdown_o,
  output logic charge_complete_o,
  output logic fault_o,
  output logic ldo_enable_o,
  output logic charge_enable_o,
  output logic [15:0] rx_power_mw_o,
  output logic irq_o
);
  // ==========================================================================
  // helpers
  localparam int CW = btcpm_pkg::CNT_W;
  localparam logic [CW-1:0] BIAS_LAST = CW'(BIAS_CYCLES - 1);
  localparam logic [CW-1:0] MON_LAST = CW'(MONITOR_CYCLES - 1);

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0] be);
    be_merge = (old & ~be_mask(be)) | (wdata & be_mask(be));
  endfunction

  // ==========================================================================
  // registers and state
  btcpm_pkg::btcpm_state_t state;
  btcpm_pkg::btcpm_state_t next_state;
  logic [CW-1:0] win_cnt;
  logic bias_on;
  logic waitreq;
  logic [31:0] rdata;
  logic [btcpm_pkg::CTRL_W-1:0] ctrl;
  logic [btcpm_pkg::IRQ_W-1:0] irq_st;
  logic [btcpm_pkg::IRQ_W-1:0] irq_en;
  logic [15:0] ref_power;
  logic [15:0] power_trim;
  logic [15:0] rx_power;
  logic power_ok;
  logic override;
  logic shutdown;
  logic complete;
  logic fault;
  logic die_sd;
  logic ldo_en;
  logic chg_en;
  logic irq;

  // ==========================================================================
  // avalon slave decode
  wire logic [3:0] idx = avs_address_i[5:2];
  wire logic req = avs_read_i || avs_write_i;
  wire logic wr_acc = avs_write_i && !waitreq;
  wire logic wr_ctrl = wr_acc && (idx == btcpm_pkg::IDX_CTRL);
  wire logic wr_clr = wr_acc && (idx == btcpm_pkg::IDX_IRQ_CLEAR);
  wire logic wr_en = wr_acc && (idx == btcpm_pkg::IDX_IRQ_ENABLE);
  wire logic wr_ref = wr_acc && (idx == btcpm_pkg::IDX_REF_POWER);
  wire logic wr_trim = wr_acc && (idx == btcpm_pkg::IDX_POWER_TRIM);
  wire logic cmd_clear = wr_acc && (idx == btcpm_pkg::IDX_CMD) &&
                         avs_byteenable_i[0] &&
                         avs_writedata_i[btcpm_pkg::CMD_CLEAR];
  wire logic [31:0] clr_bits = be_mask(avs_byteenable_i) & avs_writedata_i;
  wire logic [31:0] ctrl_wr = be_merge({30'h0, ctrl}, avs_writedata_i,
                                       avs_byteenable_i);
  wire logic [31:0] en_wr = be_merge({26'h0, irq_en}, avs_writedata_i,
                                     avs_byteenable_i);
  wire logic [31:0] ref_wr = be_merge({16'h0, ref_power}, avs_writedata_i,
                                      avs_byteenable_i);
  wire logic [31:0] trim_wr = be_merge({16'h0, power_trim}, avs_writedata_i,
                                       avs_byteenable_i);

  // ==========================================================================
  // measurement sequencer
  wire logic run = ctrl[btcpm_pkg::CTRL_RUN];
  wire logic bias_st = (state == btcpm_pkg::BTCPM_BIAS);
  wire logic mon_st = (state == btcpm_pkg::BTCPM_MONITOR);
  wire logic [CW-1:0] win_last = bias_st ? BIAS_LAST : MON_LAST;
  wire logic win_done = (win_cnt == win_last);

  always_comb
  begin
    next_state = state;
    unique case (state)
      btcpm_pkg::BTCPM_IDLE:
        if (run)
          next_state = btcpm_pkg::BTCPM_BIAS;
      btcpm_pkg::BTCPM_BIAS:
        if (!run)
          next_state = btcpm_pkg::BTCPM_IDLE;
        else if (win_done)
          next_state = btcpm_pkg::BTCPM_MONITOR;
      btcpm_pkg::BTCPM_MONITOR:
        if (!run)
          next_state = btcpm_pkg::BTCPM_IDLE;
        else if (win_done)
          next_state = btcpm_pkg::BTCPM_BIAS;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state <= btcpm_pkg::BTCPM_IDLE;
      win_cnt <= '0;
      bias_on <= 1'b0;
    end
    else
    begin
      state <= next_state;
      win_cnt <= (next_state != state) ? '0 : CW'(win_cnt + 1'b1);
      // the pin is driven only while biased, floating otherwise
      bias_on <= (next_state == btcpm_pkg::BTCPM_BIAS);
    end
  end

  // ==========================================================================
  // temperature comparators
  logic hot_f;
  logic cold_f;
  logic hot_rise;
  logic cold_rise;

  // filters only run while biased; the unbiased pin level means nothing
  btcpm_deglitch #(.CYCLES(DEGLITCH_CYCLES)) u_hot (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(bias_st),
    .raw_i(hot_cmp_i),
    .filt_o(hot_f),
    .rise_o(hot_rise)
  );

  btcpm_deglitch #(.CYCLES(DEGLITCH_CYCLES)) u_cold (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(bias_st),
    .raw_i(cold_cmp_i),
    .filt_o(cold_f),
    .rise_o(cold_rise)
  );

  // ==========================================================================
  // control pin override and shutdown flags
  wire logic hi_evt = mon_st && ctrl_high_cmp_i;
  wire logic lo_evt = mon_st && ctrl_low_cmp_i;
  // a new event in the clear cycle wins over the clear
  wire logic next_override = hi_evt || (override && !cmd_clear);
  wire logic next_complete = hi_evt || (complete && !cmd_clear);
  wire logic next_fault = lo_evt || (fault && !cmd_clear);
  wire logic next_shutdown = hi_evt || lo_evt ||
                             (shutdown && !cmd_clear);
  wire logic next_die_sd = die_at_limit_i ||
                           (die_sd && !die_cooled_i);
  wire logic in_range = !hot_f && !cold_f;
  wire logic next_chg_en = ctrl[btcpm_pkg::CTRL_CHARGE] && in_range &&
                           !next_shutdown && !next_die_sd;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      override <= 1'b0;
      complete <= 1'b0;
      fault <= 1'b0;
      shutdown <= 1'b0;
      die_sd <= 1'b0;
      ldo_en <= 1'b0;
      chg_en <= 1'b0;
    end
    else
    begin
      override <= next_override;
      complete <= next_complete;
      fault <= next_fault;
      shutdown <= next_shutdown;
      die_sd <= next_die_sd;
      ldo_en <= !next_die_sd;
      chg_en <= next_chg_en;
    end
  end

  // ==========================================================================
  // received power report
  // saturate rather than wrap so a large loss never reports as tiny
  wire logic [17:0] power_sum = {2'h0, out_power_mw_i} +
                                {2'h0, loss_power_mw_i} +
                                {2'h0, power_trim};
  wire logic [15:0] next_rx_power = (power_sum[17:16] != 2'h0) ?
                                    btcpm_pkg::POWER_SAT_MW :
                                    power_sum[15:0];
  wire logic [15:0] shortfall = ref_power - next_rx_power;
  wire logic next_power_ok = (ref_power > next_rx_power) &&
                             (shortfall < btcpm_pkg::POWER_MARGIN_MW);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rx_power <= '0;
      power_ok <= 1'b0;
    end
    else
    begin
      rx_power <= next_rx_power;
      power_ok <= next_power_ok;
    end
  end

  // ==========================================================================
  // interrupts
  wire logic [btcpm_pkg::IRQ_W-1:0] events;
  assign events[btcpm_pkg::IRQ_HOT] = hot_rise;
  assign events[btcpm_pkg::IRQ_COLD] = cold_rise;
  assign events[btcpm_pkg::IRQ_COMPLETE] = hi_evt && !complete;
  assign events[btcpm_pkg::IRQ_FAULT] = lo_evt && !fault;
  assign events[btcpm_pkg::IRQ_DIE_SD] = next_die_sd && !die_sd;
  assign events[btcpm_pkg::IRQ_CYCLE] = mon_st && win_done;
  wire logic [btcpm_pkg::IRQ_W-1:0] clr_mask =
    wr_clr ? clr_bits[btcpm_pkg::IRQ_W-1:0] : '0;
  wire logic [btcpm_pkg::IRQ_W-1:0] next_irq_st =
    events | (irq_st & ~clr_mask);

  // ==========================================================================
  // status and read mux
  wire logic [31:0] status_word;
  assign status_word[31:btcpm_pkg::ST_W] = '0;
  assign status_word[btcpm_pkg::ST_HOT] = hot_f;
  assign status_word[btcpm_pkg::ST_COLD] = cold_f;
  assign status_word[btcpm_pkg::ST_OVERRIDE] = override;
  assign status_word[btcpm_pkg::ST_SHUTDOWN] = shutdown;
  assign status_word[btcpm_pkg::ST_COMPLETE] = complete;
  assign status_word[btcpm_pkg::ST_FAULT] = fault;
  assign status_word[btcpm_pkg::ST_DIE_SD] = die_sd;
  assign status_word[btcpm_pkg::ST_CHARGING] = chg_en;
  assign status_word[btcpm_pkg::ST_POWER_OK] = power_ok;
  assign status_word[btcpm_pkg::ST_BIAS] = bias_on;

  wire logic [31:0] rd_mux =
    (idx == btcpm_pkg::IDX_CTRL) ? {30'h0, ctrl} :
    (idx == btcpm_pkg::IDX_STATUS) ? status_word :
    (idx == btcpm_pkg::IDX_IRQ_STATUS) ? {26'h0, irq_st} :
    (idx == btcpm_pkg::IDX_IRQ_ENABLE) ? {26'h0, irq_en} :
    (idx == btcpm_pkg::IDX_RX_POWER) ? {16'h0, rx_power} :
    (idx == btcpm_pkg::IDX_REF_POWER) ? {16'h0, ref_power} :
    (idx == btcpm_pkg::IDX_POWER_TRIM) ? {16'h0, power_trim} :
    32'h0000_0000;

  // ==========================================================================
  // register file, one wait state on every access
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      waitreq <= 1'b1;
      rdata <= '0;
      ctrl <= btcpm_pkg::CTRL_RESET;
      irq_en <= '0;
      irq_st <= '0;
      irq <= 1'b0;
      ref_power <= '0;
      power_trim <= '0;
    end
    else
    begin
      waitreq <= !(req && waitreq);
      if (avs_read_i && waitreq)
        rdata <= rd_mux;
      if (wr_ctrl)
        ctrl <= ctrl_wr[btcpm_pkg::CTRL_W-1:0];
      if (wr_en)
        irq_en <= en_wr[btcpm_pkg::IRQ_W-1:0];
      if (wr_ref)
        ref_power <= ref_wr[15:0];
      if (wr_trim)
        power_trim <= trim_wr[15:0];
      irq_st <= next_irq_st;
      irq <= |(next_irq_st & (wr_en ? en_wr[btcpm_pkg::IRQ_W-1:0] : irq_en));
    end
  end

  // ==========================================================================
  // outputs
  assign avs_waitrequest_o = waitreq;
  assign avs_readdata_o = rdata;
  assign sense_bias_strobe_o = bias_on;
  assign temp_sense_ctrl_pin_o = bias_on;
  assign temp_sense_ctrl_pin_oe_o = bias_on;
  assign rx_shutdown_o = shutdown;
  assign charge_complete_o = complete;
  assign fault_o = fault;
  assign ldo_enable_o = ldo_en;
  assign charge_enable_o = chg_en;
  assign rx_power_mw_o = rx_power;
  assign irq_o = irq;
endmodule
`default_nettype wire

// ### btcpm_top_checker.sv
// port-level assertion checker for the temperature monitor
`timescale 1ns/100ps
`default_nettype none
module btcpm_top_checker #(
  parameter int BIAS_CYCLES = 25,
  parameter int MONITOR_CYCLES = 100
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ctrl_high_cmp_i,
  input wire logic ctrl_low_cmp_i,
  input wire logic die_at_limit_i,
  input wire logic die_cooled_i,
  input wire logic sense_bias_strobe_o,
  input wire logic temp_sense_ctrl_pin_o,
  input wire logic temp_sense_ctrl_pin_oe_o,
  input wire logic rx_shutdown_o,
  input wire logic charge_complete_o,
  input wire logic fault_o,
  input wire logic ldo_enable_o,
  input wire logic charge_enable_o
);
  // ==========
  // run lengths; seen_bias masks the idle gap after reset
  int bias_run;
  int mon_run;
  logic seen_bias;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bias_run <= 0;
      mon_run <= 0;
      seen_bias <= 1'b0;
    end
    else
    begin
      bias_run <= sense_bias_strobe_o ? bias_run + 1 : 0;
      mon_run <= sense_bias_strobe_o ? 0 : mon_run + 1;
      seen_bias <= seen_bias | sense_bias_strobe_o;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  property p_pin;
    sense_bias_strobe_o == temp_sense_ctrl_pin_oe_o
      && sense_bias_strobe_o == temp_sense_ctrl_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin drive off strobe");
  property p_blen;
    $fell(sense_bias_strobe_o) |-> bias_run == BIAS_CYCLES;
  endproperty
  a_blen: assert property (p_blen) else $error("bias length");
  property p_mlen;
    $rose(sense_bias_strobe_o) && seen_bias |-> mon_run == MONITOR_CYCLES;
  endproperty
  a_mlen: assert property (p_mlen) else $error("monitor length");
  property p_done;
    seen_bias && !sense_bias_strobe_o && ctrl_high_cmp_i
      |-> ##[1:2] (charge_complete_o && rx_shutdown_o);
  endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_fault;
    seen_bias && !sense_bias_strobe_o && ctrl_low_cmp_i
      |-> ##[1:2] (fault_o && rx_shutdown_o);
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
  property p_nochg;
    rx_shutdown_o |-> !charge_enable_o;
  endproperty
  a_nochg: assert property (p_nochg) else $error("charging shut");
  property p_dieoff;
    die_at_limit_i |-> ##[1:2] !ldo_enable_o;
  endproperty
  a_dieoff: assert property (p_dieoff) else $error("regulator on hot");
  property p_dieon;
    $rose(ldo_enable_o) && !$past(rst_i, 2)
      |-> $past(die_cooled_i) || $past(die_cooled_i, 2);
  endproperty
  a_dieon: assert property (p_dieon) else $error("early restart");
endmodule
bind btcpm_top btcpm_top_checker #(
  .BIAS_CYCLES(BIAS_CYCLES),
  .MONITOR_CYCLES(MONITOR_CYCLES)
) u_checker (
  .mclk_i, .rst_i, .ctrl_high_cmp_i, .ctrl_low_cmp_i, .die_at_limit_i,
  .die_cooled_i, .sense_bias_strobe_o, .temp_sense_ctrl_pin_o,
  .temp_sense_ctrl_pin_oe_o, .rx_shutdown_o, .charge_complete_o, .fault_o,
  .ldo_enable_o, .charge_enable_o
);
`default_nettype wire

// ### btcpm_sense_partner.sv
// far side: thermistor network and an outside driver on the sense pin
`timescale 1ns/100ps
`default_nettype none
module btcpm_sense_partner (
  input wire logic mclk_i,
  input wire logic pin_oe_i,
  input wire logic [1:0] temp_mode_i,
  input wire logic [1:0] drive_mode_i,
  output logic hot_cmp_o,
  output logic cold_cmp_o,
  output logic ctrl_high_cmp_o,
  output logic ctrl_low_cmp_o
);
  // ==========
  // temp 0 in range, 1 hot, 2 cold, 3 hot bursts of 4 cycles
  // drive 0 none, 1 pull high, 2 pull low
  logic [2:0] wobble = 3'h0;
  wire logic hot_bias;
  always @(posedge mclk_i)
  begin
    wobble <= wobble + 3'h1;
  end
  assign hot_bias = temp_mode_i == 2'h1 || (temp_mode_i == 2'h3 && wobble[2]);
  // an unbiased pin gives no reading, so the comparators wander
  assign hot_cmp_o = pin_oe_i ? hot_bias : wobble[0];
  assign cold_cmp_o = pin_oe_i ? temp_mode_i == 2'h2 : ~wobble[0];
  // outside driver acts only while the pin is released
  assign ctrl_high_cmp_o = !pin_oe_i && drive_mode_i == 2'h1;
  assign ctrl_low_cmp_o = !pin_oe_i && drive_mode_i == 2'h2;
endmodule
`default_nettype wire

// ### test_btcpm_top.sv
// self-checking bench for the temperature sense and control pin monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module test_btcpm_top;
  // ==========
  // signals
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic die_at_limit_i = 1'b0, die_cooled_i = 1'b0;
  logic [15:0] out_power_mw_i = 16'h0, loss_power_mw_i = 16'h0;
  logic [1:0] temp_mode = 2'h0, drive_mode = 2'h0;
  logic hot_cmp_i, cold_cmp_i, ctrl_high_cmp_i, ctrl_low_cmp_i;
  logic [31:0] avs_readdata_o, q;
  logic [15:0] rx_power_mw_o;
  logic avs_waitrequest_o, sense_bias_strobe_o, temp_sense_ctrl_pin_o;
  logic temp_sense_ctrl_pin_oe_o, rx_shutdown_o, charge_complete_o, fault_o;
  logic ldo_enable_o, charge_enable_o, irq_o;
  int mismatches = 0, comparisons = 0, cycles = 0;
  // ==========
  // design and far side; short windows keep the run brief
  btcpm_top #(
    .BIAS_CYCLES(25),
    .MONITOR_CYCLES(100),
    .DEGLITCH_CYCLES(10)
  ) u_dut (
    .mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .hot_cmp_i, .cold_cmp_i, .ctrl_high_cmp_i, .ctrl_low_cmp_i,
    .die_at_limit_i, .die_cooled_i, .out_power_mw_i, .loss_power_mw_i,
    .sense_bias_strobe_o, .temp_sense_ctrl_pin_o, .temp_sense_ctrl_pin_oe_o,
    .rx_shutdown_o, .charge_complete_o, .fault_o, .ldo_enable_o,
    .charge_enable_o, .rx_power_mw_o, .irq_o
  );
  btcpm_sense_partner u_far (
    .mclk_i, .pin_oe_i(temp_sense_ctrl_pin_oe_o), .temp_mode_i(temp_mode),
    .drive_mode_i(drive_mode), .hot_cmp_o(hot_cmp_i), .cold_cmp_o(cold_cmp_i),
    .ctrl_high_cmp_o(ctrl_high_cmp_i), .ctrl_low_cmp_o(ctrl_low_cmp_i)
  );
  // ==========
  // clock, run limit and helpers
  initial
  begin
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // request held until waitrequest is seen low at a rising edge
  // only the global cycle ceiling ends a stalled wait
  task automatic bus(input logic w, input logic [3:0] idx,
                     input logic [31:0] d, input logic [3:0] be);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= {idx, 2'h0};
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do
    begin
      @(posedge mclk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] idx);
    bus(1'b0, idx, 32'h0, 4'hf);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // edges until the strobe is no longer sampled at level v
  task automatic run_of(input logic v, output int n);
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (sense_bias_strobe_o === v && n < 300);
  endtask
  // ==========
  // scenarios
  initial
  begin
    int n, e, d;
    int dt[6] = '{0, 1, 374, 375, -1, 0};
    void'($urandom(79406));
    wt(12);
    rst_i <= 1'b0;
    wt(1);
    rd(btcpm_pkg::IDX_CTRL);
    `CHK(q, 32'h3);
    rd(btcpm_pkg::IDX_IRQ_ENABLE);
    `CHK(q, 32'h0);
    wr(4'h9, 32'hffffffff);
    rd(4'h9);
    `CHK(q, 32'h0);
    run_of(1'b1, n);
    run_of(1'b0, n);
    run_of(1'b1, n);
    `CHK(n, 25);
    run_of(1'b0, n);
    `CHK(n, 100);
    for (int m = 0; m < 4; m++)
    begin
      temp_mode <= 2'(m);
      wt(260);
      rd(btcpm_pkg::IDX_STATUS);
      `CHK(q[1:0], {m == 2, m == 1});
      `CHK(charge_enable_o, m == 0 || m == 3);
    end
    wr(btcpm_pkg::IDX_IRQ_ENABLE, 32'h1 << btcpm_pkg::IRQ_COMPLETE);
    drive_mode <= 2'h1;
    wt(130);
    drive_mode <= 2'h0;
    `CHK({charge_complete_o, rx_shutdown_o, charge_enable_o}, 3'h6);
    `CHK(irq_o, 1'b1);
    rd(btcpm_pkg::IDX_STATUS);
    `CHK(q[btcpm_pkg::ST_OVERRIDE], 1'b1);
    wr(btcpm_pkg::IDX_IRQ_ENABLE, 32'h0);
    wt(2);
    `CHK(irq_o, 1'b0);
    // a clear with no byte lanes must leave the event pending
    for (int b = 0; b < 2; b++)
    begin
      bus(1'b1, btcpm_pkg::IDX_IRQ_CLEAR, 32'h4, b ? 4'hf : 4'h0);
      rd(btcpm_pkg::IDX_IRQ_STATUS);
      `CHK(q[btcpm_pkg::IRQ_COMPLETE], !b);
    end
    wr(btcpm_pkg::IDX_CMD, 32'h1);
    wt(3);
    `CHK({charge_complete_o, rx_shutdown_o, charge_enable_o}, 3'h1);
    drive_mode <= 2'h2;
    wt(130);
    drive_mode <= 2'h0;
    `CHK({fault_o, rx_shutdown_o, charge_enable_o}, 3'h6);
    wr(btcpm_pkg::IDX_CMD, 32'h1);
    die_at_limit_i <= 1'b1;
    wt(3);
    `CHK({ldo_enable_o, charge_enable_o}, 2'h0);
    die_at_limit_i <= 1'b0;
    wt(3);
    `CHK(ldo_enable_o, 1'b0);
    die_cooled_i <= 1'b1;
    wt(3);
    die_cooled_i <= 1'b0;
    `CHK({ldo_enable_o, charge_enable_o}, 2'h3);
    // bench model of the report: integer sum saturated to 16 bits
    for (int i = 0; i < 6; i++)
    begin
      n = (i == 5) ? 65000 : $urandom_range(40000);
      e = (i == 5) ? 3000 : $urandom_range(3000);
      d = $urandom_range(255);
      out_power_mw_i <= 16'(n);
      loss_power_mw_i <= 16'(e);
      wr(btcpm_pkg::IDX_POWER_TRIM, 32'(d));
      e = n + e + d;
      e = (e > 65535) ? 65535 : e;
      wt(2);
      `CHK(rx_power_mw_o, e);
      wr(btcpm_pkg::IDX_REF_POWER, 32'(16'(e + dt[i])));
      rd(btcpm_pkg::IDX_STATUS);
      `CHK(q[btcpm_pkg::ST_POWER_OK], dt[i] > 0 && dt[i] < 375);
    end
    // sticky events so far: hot, cold, fault, die, cycle end; complete cleared
    rd(btcpm_pkg::IDX_IRQ_STATUS);
    `CHK(q, 32'h3b);
    finish_test();
  end
endmodule
`default_nettype wire
